//--- common/srm_pkg.sv
/*
  Constants and types for the static RAM board bus logic.
  Assumes a 16-bit address bus, 8-bit data and a 100 MHz core clock.
*/
package srm_pkg;
  // ****************************************
  // Bus and array geometry
  // ****************************************
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int WORD_W    = DATA_W + 1;
  localparam int IDX_W     = 13;
  localparam int ARR_DEPTH = 8192;
  localparam int BASE_W    = ADDR_W - IDX_W;
  localparam int N_ARR     = 2;
  localparam int AUX_W     = 4;

  // ****************************************
  // Input synchroniser width
  // ****************************************
  localparam int SYNC_W = 3 + ADDR_W + DATA_W + 2 + AUX_W + N_ARR * BASE_W + N_ARR + 3 + AUX_W;

  // ****************************************
  // Memory clock range kept by the bus master
  // ****************************************
  localparam int MEMCLK_MIN_KHZ = 1000;
  localparam int MEMCLK_MAX_KHZ = 2000;
  localparam int CLK_KHZ        = 100000;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [AUX_W-1:0]  AUX_RST  = 4'h0;
  localparam logic              AUX_PAGE = 1'b0;
  localparam logic              RW_READ  = 1'b1;

  typedef enum logic [1:0] {
    SRM_IDLE,
    SRM_READ,
    SRM_WRITE,
    SRM_INHIBIT
  } srm_state_t;
endpackage : srm_pkg

//--- rtl/srm_bus_logic.sv
/*
  Bus-side control of a static RAM board with one or two 8K-byte arrays.
  Assumes every bus pin and switch is asynchronous to clk and that the
  memory clock phase 2 runs far slower than clk.
*/
// How it works
// [R1] Each array answers at its own switch-set base on 8K boundaries.
// [R2] Two independent 8K arrays when the large strap is set, else one.
// [R3] Top three address lines compared with each base to select an array.
// [R4] Read-only switch per array suppresses writes to that array.
// [R5] Selected cycle decodes control and switch into read, write or inhibit.
// [R6] Even parity stored on write and rechecked on read.
// [R7] Failed parity on read drives the parity error line.
// [R8] Bus hold signal keeps board in power-down hold, accesses stopped.
// [R9] Bus master runs the memory clock between 1 and 2 MHz.
// [R10] Jumper picks user map or monitor map for decoding.
// [R11] Four-line aux header carries page select inputs or parity error.
// [R12] Processor transfers memory data only in clock phase two.
// [R13] Nine bits per location; inhibited write changes nothing, no error.
`timescale 1ns/1ps
module srm_bus_logic
  import srm_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                phase2_i,
  input  wire logic                vma_i,
  input  wire logic                rw_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   data_i,
  output logic      [DATA_W-1:0]   data_o,
  output logic                     data_oe,
  input  wire logic                hold_i,
  input  wire logic                monitor_map_i,
  input  wire logic [AUX_W-1:0]    aux_i,
  output logic      [AUX_W-1:0]    aux_o,
  output logic                     aux_oe,
  input  wire logic [BASE_W-1:0]   base0_sw,
  input  wire logic [BASE_W-1:0]   base1_sw,
  input  wire logic [N_ARR-1:0]    read_only_sw,
  input  wire logic                two_arrays_sw,
  input  wire logic                monitor_map_sel,
  input  wire logic                aux_mode_sel,
  input  wire logic [AUX_W-1:0]    page_sw,
  output logic                     parity_err,
  output logic                     hold_active
);
  // ****************************************
  // Input synchroniser
  // ****************************************
  logic [SYNC_W-1:0]  meta_q;
  logic [SYNC_W-1:0]  sync_q;

  // Bus words are held through phase two, so two plain stages are enough
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      meta_q <= '0;
    else
      meta_q <= {phase2_i, vma_i, rw_i, addr_i, data_i, hold_i, monitor_map_i, aux_i,
                 base0_sw, base1_sw, read_only_sw, two_arrays_sw, monitor_map_sel,
                 aux_mode_sel, page_sw};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync_q <= '0;
    else
      sync_q <= meta_q;
  end

  logic                phi2_s;
  logic                vma_s;
  logic                rw_s;
  logic [ADDR_W-1:0]   addr_s;
  logic [DATA_W-1:0]   data_s;
  logic                hold_s;
  logic                mon_s;
  logic [AUX_W-1:0]    aux_s;
  logic [BASE_W-1:0]   base0_s;
  logic [BASE_W-1:0]   base1_s;
  logic [N_ARR-1:0]    ro_s;
  logic                two_s;
  logic                map_sel_s;
  logic                aux_mode_s;
  logic [AUX_W-1:0]    page_s;

  assign {phi2_s, vma_s, rw_s, addr_s, data_s, hold_s, mon_s, aux_s, base0_s, base1_s,
          ro_s, two_s, map_sel_s, aux_mode_s, page_s} = sync_q;

  // ****************************************
  // Phase two edges
  // ****************************************
  logic  phi2_q;
  logic  phi2_rise;
  logic  phi2_fall;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      phi2_q <= 1'b0;
    else
      phi2_q <= phi2_s;
  end

  // [R12] Phase two framing
  assign phi2_rise = phi2_s & ~phi2_q;
  assign phi2_fall = ~phi2_s & phi2_q;

  // ****************************************
  // Address decode
  // ****************************************
  logic [BASE_W-1:0]  base_s [N_ARR];
  logic [BASE_W-1:0]  addr_base;
  logic [N_ARR-1:0]   hit;
  logic               map_ok;
  logic               page_ok;
  logic               cyc_ok;
  logic               any_hit;
  logic               arr_sel;
  logic               take_cyc;

  assign base_s[0] = base0_s;
  assign base_s[1] = base1_s;
  assign addr_base = addr_s[ADDR_W-1:IDX_W];

  // [R10] Map jumper match
  assign map_ok  = (mon_s == map_sel_s);
  // [R11] Page select inputs
  assign page_ok = (aux_mode_s != AUX_PAGE) || (aux_s == page_s);
  assign cyc_ok  = vma_s && map_ok && page_ok;

  // [R1] [R2] [R3] Full decode per array
  always_comb
  begin
    for (int i = 0; i < N_ARR; i++)
      hit[i] = cyc_ok && (addr_base == base_s[i]) && ((i == 0) || two_s);
  end

  // Array zero wins if both bases are set alike
  assign any_hit  = |hit;
  assign arr_sel  = ~hit[0];
  // [R8] Hold refuses every new cycle
  assign take_cyc = phi2_rise && any_hit && !hold_s;

  // ****************************************
  // Cycle control
  // ****************************************
  srm_state_t         state_q;
  logic               sel_q;
  logic [IDX_W-1:0]   idx_q;
  logic               wr_store;
  logic               rd_drive;
  logic               rd_check;

  // One action per phase two; a new cycle is only taken from idle
  // [R4] [R5] Choose cycle action
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= SRM_IDLE;
    // [R8] No access in hold
    else if (hold_s)
      state_q <= SRM_IDLE;
    else
    begin
      case (state_q)
        SRM_IDLE:
        begin
          if (take_cyc && (rw_s == RW_READ))
            state_q <= SRM_READ;
          else if (take_cyc && ro_s[arr_sel])
            state_q <= SRM_INHIBIT;
          else if (take_cyc)
            state_q <= SRM_WRITE;
        end
        SRM_READ,
        SRM_WRITE,
        SRM_INHIBIT:
        begin
          if (phi2_fall)
            state_q <= SRM_IDLE;
        end
        default:
          state_q <= SRM_IDLE;
      endcase
    end
  end

  // Array and index held for the whole phase two
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sel_q <= 1'b0;
      idx_q <= '0;
    end
    else if (take_cyc)
    begin
      sel_q <= arr_sel;
      idx_q <= addr_s[IDX_W-1:0];
    end
  end

  // Write lands at the phase two fall, when bus data has settled
  assign wr_store = phi2_fall && (state_q == SRM_WRITE) && !hold_s;
  assign rd_drive = (state_q == SRM_READ) && !phi2_fall && !hold_s;
  // An inhibited cycle reaches none of these, so all nine bits stay put
  assign rd_check = (state_q == SRM_READ) && phi2_fall;

  // ****************************************
  // Storage, nine bits a location
  // ****************************************
  logic [WORD_W-1:0]  mem_q [N_ARR][ARR_DEPTH];
  logic [WORD_W-1:0]  rd_word;
  logic               wr_par;

  // [R6] Even parity over the stored nine bits
  assign wr_par = ^data_s;

  // No reset on the array: contents must outlive a reset
  // [R6] [R13] Store data with parity
  always_ff @(posedge clk)
  begin
    if (wr_store)
      mem_q[sel_q][idx_q] <= {wr_par, data_s};
  end

  assign rd_word = mem_q[sel_q][idx_q];

  // ****************************************
  // Read data drive
  // ****************************************
  // Zero when idle, so a stray enable never shows a stale byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_o <= DATA_RST;
    else if (rd_drive)
      data_o <= rd_word[DATA_W-1:0];
    else
      data_o <= DATA_RST;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_oe <= 1'b0;
    else
      data_oe <= rd_drive;
  end

  // ****************************************
  // Parity error report
  // ****************************************
  logic  perr_q;

  // Held from the failing read until the next selected cycle
  // Set wins over clear, so no failing read is ever lost
  // [R6] [R7] Recheck on read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      perr_q <= 1'b0;
    else if (rd_check && (^rd_word))
      perr_q <= 1'b1;
    else if (take_cyc)
      perr_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      parity_err <= 1'b0;
    else
      parity_err <= perr_q;
  end

  // ****************************************
  // Aux header and hold status
  // ****************************************
  // [R11] Aux line carries parity error
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      aux_o <= AUX_RST;
    else
      aux_o <= {{(AUX_W-1){1'b0}}, perr_q};
  end

  // Page mode leaves the header to the bus, so no drive there
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      aux_oe <= 1'b0;
    else
      aux_oe <= (aux_mode_s != AUX_PAGE);
  end

  // [R8] Hold status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hold_active <= 1'b0;
    else
      hold_active <= hold_s;
  end

endmodule // srm_bus_logic

//--- testbench/srm_checker_assertions.sv
/*
  Port checker for the RAM board bus logic.
  Assumes one clk domain, async high rst.
*/
`timescale 1ns/1ps
module srm_checker
  import srm_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              phase2_i,
  input wire logic              rw_i,
  input wire logic              hold_i,
  input wire logic              aux_mode_sel,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic              data_oe,
  input wire logic              aux_oe,
  input wire logic              parity_err,
  input wire logic              hold_active
);
  // ****************
  // Port relations
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Error must follow a read by a few clocks
  logic [4:0] oe_hist_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      oe_hist_q <= 5'h00;
    else
      oe_hist_q <= {oe_hist_q[3:0], data_oe};
  hold_sync_a: assert property (hold_i [*5] |-> hold_active)
    else $error("hold not reported");
  oe_hold_a: assert property ($rose(data_oe) |-> !hold_active)
    else $error("read during hold");
  oe_cause_a: assert property ($rose(data_oe) |-> $past(rw_i, 3) && $past(phase2_i, 3))
    else $error("drive without read");
  read_len_a: assert property ($rose(data_oe) |-> data_oe [*3])
    else $error("read drive too short");
  oe_drop_a: assert property ($fell(phase2_i) |-> ##[1:6] !data_oe)
    else $error("drive past phase two");
  idle_zero_a: assert property (!data_oe |-> data_o == 8'h00)
    else $error("idle data not zero");
  aux_dir_a: assert property (aux_mode_sel [*5] |-> aux_oe)
    else $error("aux not driven");
  perr_cause_a: assert property ($rose(parity_err) |-> |oe_hist_q)
    else $error("error without read");
  cover property ($rose(data_oe));
  cover property ($fell(phase2_i) && !rw_i);
  cover property (hold_active && phase2_i);
endmodule // srm_checker

bind srm_bus_logic srm_checker i_chk (.*);

//--- testbench/srm_master.sv
/*
  Bus master model for the RAM board.
  Assumes clk is the 100 MHz core clock.
*/
`timescale 1ns/1ps
module srm_master
  import srm_pkg::*;
(
  input  wire logic              clk,
  output logic                   phase2_i,
  output logic                   vma_i,
  output logic                   rw_i,
  output logic      [ADDR_W-1:0] addr_i,
  output logic      [DATA_W-1:0] data_i,
  input  wire logic [DATA_W-1:0] data_o,
  input  wire logic              data_oe
);
  // ****************
  // Bus cycle
  // ****************
  initial {phase2_i, vma_i, rw_i, addr_i, data_i} = '0;
  // 2 MHz, transfer in phase two
  task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oe);
    @(posedge clk);
    vma_i <= 1'b1;
    rw_i <= rd;
    addr_i <= a;
    data_i <= d;
    phase2_i <= 1'b1;
    repeat (25) @(posedge clk);
    q = data_o;
    oe = data_oe;
    phase2_i <= 1'b0;
    repeat (4) @(posedge clk);
    vma_i <= 1'b0;
    // Released bus shows no stale byte
    data_i <= ~d;
    repeat (21) @(posedge clk);
  endtask
endmodule // srm_master

//--- testbench/static_ram_module_bus_logic_bench.sv
/*
  Self-checking bench for the RAM board bus logic.
  Assumes the master model owns the bus pins.
*/
`timescale 1ns/1ps
module static_ram_module_bus_logic_bench;
  import srm_pkg::*;
  // ****************
  // Scenarios
  // ****************
  logic              clk = 1'b0, rst = 1'b1, phase2_i, vma_i, rw_i, data_oe, oe;
  logic              hold_i = 1'b0, monitor_map_i = 1'b0, two_arrays_sw = 1'b1;
  logic              monitor_map_sel = 1'b0, aux_mode_sel = 1'b1, aux_oe;
  logic              parity_err, hold_active;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] data_i, data_o, q;
  logic [AUX_W-1:0]  aux_i = 4'h0, page_sw = 4'h0, aux_o;
  logic [BASE_W-1:0] base0_sw = 3'h1, base1_sw = 3'h6;
  logic [N_ARR-1:0]  read_only_sw = 2'h0;
  int                err_count = 0, compares = 0, cyc = 0;
  always #5 clk = ~clk;
  srm_bus_logic i_dut (.*);
  srm_master i_bm (.*);
  task automatic close_out;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Switches pass a synchroniser first
  task automatic st;
    repeat (6) @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_bm.acc(1'b0, a, d, q, oe);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic e);
    i_bm.acc(1'b1, a, 8'h00, q, oe);
    chk("oe", {7'h0, e}, {7'h0, oe});
    // Unselected or refused cycles leave the data lines at zero
    chk("data", d, q);
  endtask
  task automatic t_rw;
    wr(16'h2000, 8'hA5);
    wr(16'h3FFF, 8'h3C);
    wr(16'hC000, 8'h5A);
    rd(16'h2000, 8'hA5, 1'b1);
    rd(16'h3FFF, 8'h3C, 1'b1);
    rd(16'hC000, 8'h5A, 1'b1);
    rd(16'h4000, 8'h00, 1'b0);
    rd(16'h1FFF, 8'h00, 1'b0);
    chk("perr", 8'h00, {7'h0, parity_err});
    two_arrays_sw <= 1'b0;
    st;
    rd(16'hC000, 8'h00, 1'b0);
    two_arrays_sw <= 1'b1;
  endtask
  task automatic t_ro;
    read_only_sw <= 2'h2;
    st;
    wr(16'hC000, 8'hFF);
    rd(16'hC000, 8'h5A, 1'b1);
    chk("perr", 8'h00, {7'h0, parity_err});
    wr(16'h2000, 8'h96);
    rd(16'h2000, 8'h96, 1'b1);
    read_only_sw <= 2'h0;
  endtask
  task automatic t_map;
    monitor_map_i <= 1'b1;
    st;
    rd(16'h2000, 8'h00, 1'b0);
    monitor_map_sel <= 1'b1;
    st;
    rd(16'h2000, 8'h96, 1'b1);
  endtask
  task automatic t_aux;
    {aux_mode_sel, page_sw, aux_i} <= 9'h035;
    st;
    chk("aux_oe", 8'h00, {7'h0, aux_oe});
    rd(16'h2000, 8'h00, 1'b0);
    aux_i <= 4'h3;
    st;
    rd(16'h2000, 8'h96, 1'b1);
    aux_mode_sel <= 1'b1;
    st;
    chk("aux_oe", 8'h01, {7'h0, aux_oe});
    chk("aux_o", 8'h00, {4'h0, aux_o});
  endtask
  task automatic t_hold;
    hold_i <= 1'b1;
    st;
    chk("hold", 8'h01, {7'h0, hold_active});
    wr(16'h2000, 8'h00);
    rd(16'h2000, 8'h00, 1'b0);
    hold_i <= 1'b0;
    st;
    chk("hold", 8'h00, {7'h0, hold_active});
    rd(16'h2000, 8'h96, 1'b1);
  endtask
  // Moved base, then both bases alike: array zero must answer
  task automatic t_base;
    base0_sw <= 3'h7;
    st;
    rd(16'hE000, 8'h96, 1'b1);
    rd(16'h2000, 8'h00, 1'b0);
    base0_sw <= 3'h6;
    st;
    rd(16'hC000, 8'h96, 1'b1);
    base0_sw <= 3'h1;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      close_out;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    st;
    chk("hold", 8'h00, {7'h0, hold_active});
    t_rw;
    t_ro;
    t_map;
    t_aux;
    t_hold;
    t_base;
    close_out;
  end
endmodule // static_ram_module_bus_logic_bench
